// File: core/dio_pkg.sv
// constants, enumerations and carriers of the six line digital i/o port
package dio_pkg;
    localparam int NUM_LINES = 6;
    localparam int AW        = 8;
    localparam int DW        = 32;

    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_LEVELS = 8'h08;
    localparam logic [7:0] OFS_DRIVE  = 8'h0c;
    localparam logic [7:0] OFS_CFG0   = 8'h10;
    localparam logic [7:0] OFS_MANIN0 = 8'h30;
    localparam logic [7:0] SPAN_LINES = 8'h18;

    localparam int CTRL_ARM_EXT  = 2;
    localparam int CTRL_TRIG_EXT = 3;
    localparam int STAT_FAULT    = 0;
    localparam int STAT_REFUSED  = 1;
    localparam int STAT_QERR     = 2;
    localparam logic [9:0] ERR_NOT_MANUAL = 10'h1fc;

    localparam int CLK_PERIOD_NS   = 20;
    localparam int TRIG_LATENCY_NS = 5000;
    localparam int TRIG_LAT_CYC    = TRIG_LATENCY_NS / CLK_PERIOD_NS;
    localparam int MIN_PULSE_NS    = 4000;
    localparam int MIN_PULSE_CYC   = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MC_MIN_NS       = 10000;
    localparam int MC_MAX_NS       = 30000;
    localparam int MC_MIN_CYC      = (MC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MC_MAX_CYC      = MC_MAX_NS / CLK_PERIOD_NS;
    localparam int MC_CW           = 11;
    localparam logic [MC_CW-1:0] MC_PULSE_CYC = MC_CW'((MC_MIN_CYC + MC_MAX_CYC) / 2);

    typedef enum logic [1:0] {WORK_SUPPLY, WORK_BATT_TEST, WORK_BATT_SIM} work_t;
    typedef enum logic [2:0] {
        MODE_MAN_IN, MODE_TRIG_IN, MODE_METER_DONE, MODE_FAULT_OUT,
        MODE_COND_OUT, MODE_ACT_IN, MODE_MAN_HIGH, MODE_MAN_LOW
    } mode_t;
    typedef enum logic [3:0] {
        ACT_SINK_SOURCE, ACT_ABOVE, ACT_BELOW, ACT_REG_FLIP, ACT_END, ACT_FULL,
        ACT_EMPTY, ACT_OUT_ON, ACT_OUT_OFF, ACT_SCRIPT_START, ACT_SCRIPT_STOP
    } action_t;
    typedef enum logic [1:0] {VAR_RISE, VAR_FALL, VAR_HIGH, VAR_LOW} var_t;

    typedef struct packed {
        var_t    variation;
        action_t action;
        mode_t   mode;
    } line_cfg_t;

    typedef struct packed {
        logic          wr;
        logic          rd;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic meas_done;
        logic prot_fault;
        logic sinking;
        logic constant_voltage;
        logic voltage_above_limit;
        logic voltage_below_limit;
        logic end_met;
        logic batt_full;
        logic batt_empty;
    } inst_state_t;

    typedef struct packed {
        logic trig_in;
        logic output_on;
        logic output_off;
        logic script_start;
        logic script_stop;
        logic query_err;
    } evt_t;

    typedef struct packed {
        work_t                      work;
        logic                       arm_ext;
        logic                       trig_ext;
        line_cfg_t [NUM_LINES-1:0]  cfg;
        logic [NUM_LINES-1:0]       sync1;
        logic [NUM_LINES-1:0]       sync2;
        logic [NUM_LINES-1:0]       level;
        logic [NUM_LINES-1:0]       latch;
        logic [NUM_LINES-1:0]       armed;
        logic [NUM_LINES-1:0]       drive_low;
        logic                       fault;
        logic                       refused;
        logic                       qerr;
        logic [MC_CW-1:0]           mc_cnt;
        logic                       prev_sinking;
        logic                       prev_cv;
        evt_t                       evt;
        logic [DW-1:0]              rdata;
    } state_t;

    localparam state_t STATE_RST = '0;
endpackage : dio_pkg

// File: core/six_line_dio.sv
// six line digital i/o port with mode control, condition outputs and action inputs
`timescale 1ns/100ps
module six_line_dio (
    input  wire logic                  sys_clk, // 50 mhz system clock
    input  wire logic                  rst_b,   // asynchronous reset, low active
    input  wire logic                  clk_en,  // freezes all state while low
    input  wire dio_pkg::bus_req_t     req,     // register write/read request
    output logic [dio_pkg::DW-1:0]     rdata_o, // read data, cycle after read
    input  wire dio_pkg::inst_state_t  inst,    // instrument state and events
    input  wire logic [5:0]            line_i,  // pin levels seen at the port
    output logic [5:0]                 line_o,  // pin output value, always low
    output logic [5:0]                 line_oe, // high while the switch sinks
    output dio_pkg::evt_t              evt_o    // one-cycle action events
);

    ////////////////////////////////////////////////////////////////////////////
    // legality of a line configuration

    function automatic logic cfg_legal(input int idx, input dio_pkg::line_cfg_t c,
                                       input dio_pkg::work_t w);
        logic batt;
        logic bt;
        logic bs;
        logic mid;
        logic ok;
        batt = (w != dio_pkg::WORK_SUPPLY);
        bt   = (w == dio_pkg::WORK_BATT_TEST);
        bs   = (w == dio_pkg::WORK_BATT_SIM);
        mid  = (idx == 1) || (idx >= 3);
        ok   = 1'b1;
        if (c.mode == dio_pkg::MODE_TRIG_IN) begin
            ok = (idx == 0);
        end else if (c.mode == dio_pkg::MODE_METER_DONE) begin
            ok = (idx == 1) && !batt;
        end else if (c.mode == dio_pkg::MODE_FAULT_OUT) begin
            ok = (idx == 2);
        end else if (c.mode == dio_pkg::MODE_COND_OUT) begin
            case (c.action)
                dio_pkg::ACT_SINK_SOURCE, dio_pkg::ACT_ABOVE,
                dio_pkg::ACT_BELOW:   ok = mid && batt;
                dio_pkg::ACT_REG_FLIP,
                dio_pkg::ACT_END:     ok = mid && bt;
                dio_pkg::ACT_FULL,
                dio_pkg::ACT_EMPTY:   ok = mid && bs;
                default:              ok = 1'b0;
            endcase
        end else if (c.mode == dio_pkg::MODE_ACT_IN) begin
            case (c.action)
                dio_pkg::ACT_OUT_ON,
                dio_pkg::ACT_OUT_OFF:      ok = mid && batt;
                dio_pkg::ACT_SCRIPT_START,
                dio_pkg::ACT_SCRIPT_STOP:  ok = mid && bt;
                default:                   ok = 1'b0;
            endcase
        end
        return ok;
    endfunction : cfg_legal

    ////////////////////////////////////////////////////////////////////////////
    // state

    dio_pkg::state_t s_q;
    dio_pkg::state_t s_d;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q       <= dio_pkg::STATE_RST;
            // pins idle high on pull-ups; zeros here would fake an edge at release
            s_q.sync1 <= '1;
            s_q.sync2 <= '1;
            s_q.level <= '1;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign line_o  = '0;
    assign line_oe = s_q.drive_low;
    assign rdata_o = s_q.rdata;
    assign evt_o   = s_q.evt;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        dio_pkg::state_t     n;
        dio_pkg::line_cfg_t  nc;
        logic [15:0]         cond_v;
        logic                c;
        logic                hit;
        logic                act_lvl;
        logic                low;
        logic [7:0]          off;
        logic [2:0]          idx;
        n      = s_q;
        nc     = '0;
        cond_v = '0;
        c      = 1'b0;
        hit    = 1'b0;
        act_lvl = 1'b0;
        low    = 1'b0;
        off    = '0;
        idx    = '0;
        n.evt   = '0;
        n.rdata = '0;

        // first stage feeds only the second
        n.sync1 = line_i;
        n.sync2 = s_q.sync1;
        n.level = s_q.sync2;
        n.prev_sinking = inst.sinking;
        n.prev_cv      = inst.constant_voltage;

        cond_v[dio_pkg::ACT_SINK_SOURCE] = inst.sinking ^ s_q.prev_sinking;
        cond_v[dio_pkg::ACT_ABOVE] = inst.voltage_above_limit;
        cond_v[dio_pkg::ACT_BELOW] = inst.voltage_below_limit;
        cond_v[dio_pkg::ACT_REG_FLIP] = (inst.constant_voltage ^ s_q.prev_cv)
                                        && (s_q.work == dio_pkg::WORK_BATT_TEST);
        cond_v[dio_pkg::ACT_END] = inst.end_met
                                   && (s_q.work == dio_pkg::WORK_BATT_TEST);
        cond_v[dio_pkg::ACT_FULL] = inst.batt_full
                                    && (s_q.work == dio_pkg::WORK_BATT_SIM);
        cond_v[dio_pkg::ACT_EMPTY] = inst.batt_empty
                                     && (s_q.work == dio_pkg::WORK_BATT_SIM);

        // set wins over a clear in the same cycle
        if (inst.prot_fault) begin
            n.fault = 1'b1;
        end

        // a request arriving mid-pulse is dropped; a retrigger would stretch it
        if (s_q.mc_cnt != '0) begin
            n.mc_cnt = s_q.mc_cnt - 1'b1;
        end else if (inst.meas_done && s_q.cfg[1].mode == dio_pkg::MODE_METER_DONE) begin
            n.mc_cnt = dio_pkg::MC_PULSE_CYC;
        end

        for (int i = 0; i < dio_pkg::NUM_LINES; i++) begin
            low = 1'b0;
            case (s_q.cfg[i].mode)
                dio_pkg::MODE_TRIG_IN: begin
                    if (s_q.level[i] && !s_q.sync2[i]) begin
                        n.evt.trig_in = 1'b1;
                    end
                end
                dio_pkg::MODE_METER_DONE: begin
                    low = (s_q.mc_cnt != '0);
                end
                dio_pkg::MODE_FAULT_OUT: begin
                    low = s_q.fault;
                end
                dio_pkg::MODE_COND_OUT: begin
                    c = cond_v[s_q.cfg[i].action];
                    case (s_q.cfg[i].variation)
                        dio_pkg::VAR_RISE: begin
                            n.latch[i] = s_q.latch[i] | c;
                            low = !s_q.latch[i];
                        end
                        dio_pkg::VAR_FALL: begin
                            n.latch[i] = s_q.latch[i] | c;
                            low = s_q.latch[i];
                        end
                        dio_pkg::VAR_HIGH: low = !c;
                        default:           low = c;
                    endcase
                end
                dio_pkg::MODE_ACT_IN: begin
                    case (s_q.cfg[i].variation)
                        dio_pkg::VAR_RISE: hit = s_q.sync2[i] && !s_q.level[i];
                        dio_pkg::VAR_FALL: hit = !s_q.sync2[i] && s_q.level[i];
                        default: begin
                            // level variations fire once per entry into the level
                            act_lvl = (s_q.cfg[i].variation == dio_pkg::VAR_HIGH)
                                      ? s_q.sync2[i] : !s_q.sync2[i];
                            hit = act_lvl && s_q.armed[i];
                            n.armed[i] = !act_lvl;
                        end
                    endcase
                    if (hit) begin
                        case (s_q.cfg[i].action)
                            dio_pkg::ACT_OUT_ON:       n.evt.output_on = 1'b1;
                            dio_pkg::ACT_OUT_OFF:      n.evt.output_off = 1'b1;
                            dio_pkg::ACT_SCRIPT_START: n.evt.script_start = 1'b1;
                            dio_pkg::ACT_SCRIPT_STOP:  n.evt.script_stop = 1'b1;
                            default:                   ;
                        endcase
                    end
                    hit = 1'b0;
                end
                dio_pkg::MODE_MAN_LOW:  low = 1'b1;
                default:                low = 1'b0;
            endcase
            n.drive_low[i] = low;
        end

        ////////////////////////////////////////////////////////////////////////
        // register writes

        off = req.addr - dio_pkg::OFS_CFG0;
        if (req.wr) begin
            if (req.addr == dio_pkg::OFS_CTRL) begin
                if (req.wdata[1:0] == 2'h3) begin
                    n.refused = 1'b1;
                end else begin
                    n.work = dio_pkg::work_t'(req.wdata[1:0]);
                    // configs that the new work mode forbids fall back to input
                    for (int i = 0; i < dio_pkg::NUM_LINES; i++) begin
                        if (!cfg_legal(i, s_q.cfg[i], n.work)) begin
                            n.cfg[i] = '0;
                        end
                    end
                end
                n.arm_ext  = req.wdata[dio_pkg::CTRL_ARM_EXT];
                n.trig_ext = req.wdata[dio_pkg::CTRL_TRIG_EXT];
            end else if (req.addr == dio_pkg::OFS_STATUS) begin
                if (req.wdata[dio_pkg::STAT_FAULT] && !inst.prot_fault) begin
                    n.fault = 1'b0;
                end
                if (req.wdata[dio_pkg::STAT_REFUSED]) begin
                    n.refused = 1'b0;
                end
                if (req.wdata[dio_pkg::STAT_QERR]) begin
                    n.qerr = 1'b0;
                end
            end else if (off < dio_pkg::SPAN_LINES && req.addr[1:0] == 2'h0) begin
                idx = off[4:2];
                nc.mode      = dio_pkg::mode_t'(req.wdata[2:0]);
                nc.action    = dio_pkg::action_t'(req.wdata[7:4]);
                nc.variation = dio_pkg::var_t'(req.wdata[9:8]);
                if (cfg_legal(int'(idx), nc, s_q.work)) begin
                    n.cfg[idx]   = nc;
                    n.latch[idx] = 1'b0;
                    n.armed[idx] = 1'b0;
                end else begin
                    n.refused = 1'b1;
                end
            end
        end

        if (n.arm_ext || n.trig_ext) begin
            n.cfg[0].mode = dio_pkg::MODE_TRIG_IN;
        end

        ////////////////////////////////////////////////////////////////////////
        // register reads, answered in the next cycle only

        off = req.addr - dio_pkg::OFS_MANIN0;
        if (req.rd) begin
            if (req.addr == dio_pkg::OFS_CTRL) begin
                n.rdata = {28'h0, s_q.trig_ext, s_q.arm_ext, s_q.work};
            end else if (req.addr == dio_pkg::OFS_STATUS) begin
                n.rdata = {6'h0, s_q.qerr ? dio_pkg::ERR_NOT_MANUAL : 10'h0, 12'h0,
                           s_q.mc_cnt != '0, s_q.qerr, s_q.refused, s_q.fault};
            end else if (req.addr == dio_pkg::OFS_LEVELS) begin
                n.rdata = {26'h0, s_q.level};
            end else if (req.addr == dio_pkg::OFS_DRIVE) begin
                n.rdata = {26'h0, s_q.drive_low};
            end else if ((req.addr - dio_pkg::OFS_CFG0) < dio_pkg::SPAN_LINES
                         && req.addr[1:0] == 2'h0) begin
                idx = 3'((req.addr - dio_pkg::OFS_CFG0) >> 2);
                n.rdata = {22'h0, s_q.cfg[idx].variation, s_q.cfg[idx].action,
                           1'b0, s_q.cfg[idx].mode};
            end else if (off < dio_pkg::SPAN_LINES && req.addr[1:0] == 2'h0) begin
                idx = off[4:2];
                if (s_q.cfg[idx].mode == dio_pkg::MODE_MAN_IN) begin
                    n.rdata = {31'h0, s_q.level[idx]};
                end else begin
                    n.evt.query_err = 1'b1;
                    n.qerr = 1'b1;
                end
            end
        end

        s_d = n;
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b || !clk_en);

    sequence s_trig_fall;
        s_q.cfg[0].mode == dio_pkg::MODE_TRIG_IN && $fell(line_i[0]) ##1 !line_i[0];
    endsequence

    sequence s_meter_start;
        s_q.cfg[1].mode == dio_pkg::MODE_METER_DONE && inst.meas_done && s_q.mc_cnt == '0;
    endsequence

    property p_trig_lines_only_first;
        s_q.cfg[1].mode != dio_pkg::MODE_TRIG_IN && s_q.cfg[2].mode != dio_pkg::MODE_TRIG_IN
            && s_q.cfg[3].mode != dio_pkg::MODE_TRIG_IN
            && s_q.cfg[4].mode != dio_pkg::MODE_TRIG_IN
            && s_q.cfg[5].mode != dio_pkg::MODE_TRIG_IN;
    endproperty
    a_trig_lines_only_first: assert property (p_trig_lines_only_first)
        else $error("trigger mode on a line other than the first");

    property p_trig_event;
        s_trig_fall |-> ##[0:2] evt_o.trig_in;
    endproperty
    a_trig_event: assert property (p_trig_event)
        else $error("falling trigger edge gave no event");

    property p_trig_needs_mode;
        evt_o.trig_in |-> $past(s_q.cfg[0].mode) == dio_pkg::MODE_TRIG_IN;
    endproperty
    a_trig_needs_mode: assert property (p_trig_needs_mode)
        else $error("trigger event without trigger mode");

    property p_meter_pulse;
        s_meter_start |=> s_q.mc_cnt == dio_pkg::MC_PULSE_CYC ##1 line_oe[1];
    endproperty
    a_meter_pulse: assert property (p_meter_pulse)
        else $error("meter complete pulse not started at its length");

    property p_fault_low;
        inst.prot_fault && s_q.cfg[2].mode == dio_pkg::MODE_FAULT_OUT
            ##1 s_q.cfg[2].mode == dio_pkg::MODE_FAULT_OUT |=> line_oe[2];
    endproperty
    a_fault_low: assert property (p_fault_low)
        else $error("fault line not low after protection fault");

    property p_fault_hold;
        s_q.fault && !(req.wr && req.addr == dio_pkg::OFS_STATUS) |=> s_q.fault;
    endproperty
    a_fault_hold: assert property (p_fault_hold)
        else $error("fault cleared without a clear write");

    property p_man_low;
        s_q.cfg[3].mode == dio_pkg::MODE_MAN_LOW [*2] |-> line_oe[3];
    endproperty
    a_man_low: assert property (p_man_low)
        else $error("manual low line not sinking");

    property p_man_high;
        s_q.cfg[3].mode == dio_pkg::MODE_MAN_HIGH [*2] |-> !line_oe[3];
    endproperty
    a_man_high: assert property (p_man_high)
        else $error("manual high line sinking");

    property p_levels_read;
        req.rd && req.addr == dio_pkg::OFS_LEVELS |=> rdata_o[5:0] == $past(s_q.level);
    endproperty
    a_levels_read: assert property (p_levels_read)
        else $error("level readback mismatch");

    property p_query_err;
        req.rd && req.addr == dio_pkg::OFS_MANIN0
            && s_q.cfg[0].mode != dio_pkg::MODE_MAN_IN |=> evt_o.query_err && rdata_o == '0;
    endproperty
    a_query_err: assert property (p_query_err)
        else $error("query on non-manual line gave no error");

endmodule : six_line_dio

// File: verification/dio_partner.sv
// far side model: pull-ups, pulse driver and active-low loads
`timescale 1ns/100ps
module dio_partner (
    input  wire logic       sys_clk, // port clock
    input  wire logic [5:0] line_oe, // device sink enables
    output logic [5:0]      line_i,  // resolved pin levels
    output logic [5:0]      load_on  // loads lit by a low line
);
    logic [5:0] ext_low_q = 6'h00;
    // pull-ups win unless someone sinks the line
    assign line_i  = ~(line_oe | ext_low_q);
    assign load_on = ~line_i;
    task automatic pull_low(input int n, input int cyc);
        @(posedge sys_clk) ext_low_q[n] <= 1'b1;
        repeat (cyc) @(posedge sys_clk);
        ext_low_q[n] <= 1'b0;
    endtask : pull_low
endmodule : dio_partner

// File: verification/six_line_dio_bench.sv
// self-checking bench of the six line digital i/o port
`timescale 1ns/100ps
module six_line_dio_bench;
    logic                 sys_clk;
    logic                 rst_b;
    logic                 clk_en;
    dio_pkg::bus_req_t    req;
    dio_pkg::inst_state_t inst;
    dio_pkg::evt_t        evt_o;
    logic [31:0]          rdata_o;
    logic [5:0]           line_i, line_o, line_oe, load_on;
    int                   bad_count, comparisons;
    six_line_dio six_line_dio_i (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
        .req(req), .rdata_o(rdata_o), .inst(inst), .line_i(line_i), .line_o(line_o),
        .line_oe(line_oe), .evt_o(evt_o));
    dio_partner dio_partner_i (.sys_clk(sys_clk), .line_oe(line_oe), .line_i(line_i),
        .load_on(load_on));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
////////////////////////////////
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk) req <= '0;
        tick(1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge sys_clk) req <= '0;
        #1 chk(rdata_o, exp);
    endtask : rd
    task automatic cfg(input int n, input logic [31:0] d);
        wr(dio_pkg::OFS_CFG0 + 8'(4 * n), d);
    endtask : cfg
    // a wait that runs out ends the run at once
    task automatic wait_sig(input int b, input int lim, input bit pin);
        int n;
        #1;
        for (n = 0; n < lim && (pin ? line_oe[b] : evt_o[b]) !== 1'b1; n++) tick(1);
        chk(32'(n < lim), 32'h1);
        if (n == lim) give_verdict();
    endtask : wait_sig
////////////////////////////////
    task automatic t_basic();
        rd(dio_pkg::OFS_STATUS, 32'h0);
        rd(dio_pkg::OFS_LEVELS, 32'h3f);
        rd(8'h28, 32'h0);
        cfg(3, 32'h7);
        rd(dio_pkg::OFS_DRIVE, 32'h8);
        chk(32'(line_o), 32'h0);
        rd(dio_pkg::OFS_LEVELS, 32'h37);
        cfg(3, 32'h6);
        rd(dio_pkg::OFS_DRIVE, 32'h0);
        cfg(0, 32'h2);
        rd(dio_pkg::OFS_STATUS, 32'h2);
        wr(dio_pkg::OFS_STATUS, 32'h2);
        rd(dio_pkg::OFS_MANIN0, 32'h1);
        wr(dio_pkg::OFS_CTRL, 32'h8);
        rd(dio_pkg::OFS_MANIN0, 32'h0);
        wait_sig(0, 2, 1'b0);
        rd(dio_pkg::OFS_STATUS, 32'h01fc0004);
        wr(dio_pkg::OFS_STATUS, 32'h4);
        $display("test basic done");
    endtask : t_basic
    task automatic t_trig();
        fork
            dio_partner_i.pull_low(0, dio_pkg::MIN_PULSE_CYC);
            wait_sig(5, dio_pkg::TRIG_LAT_CYC, 1'b0);
        join
        repeat (8) begin
            tick(1);
            chk(32'(evt_o.trig_in), 32'h0);
        end
        $display("test trig done");
    endtask : t_trig
    task automatic t_meter_fault();
        int n;
        cfg(1, 32'h2);
        @(posedge sys_clk) inst.meas_done <= 1'b1;
        @(posedge sys_clk) inst.meas_done <= 1'b0;
        wait_sig(1, 4, 1'b1);
        for (n = 0; n < 2000 && line_oe[1] === 1'b1; n++) tick(1);
        chk(32'(n >= dio_pkg::MC_MIN_CYC && n <= dio_pkg::MC_MAX_CYC), 32'h1);
        cfg(2, 32'h3);
        rd(dio_pkg::OFS_DRIVE, 32'h0);
        @(posedge sys_clk) inst.prot_fault <= 1'b1;
        @(posedge sys_clk) inst.prot_fault <= 1'b0;
        wait_sig(2, 4, 1'b1);
        tick(20);
        rd(dio_pkg::OFS_DRIVE, 32'h4);
        rd(dio_pkg::OFS_STATUS, 32'h1);
        wr(dio_pkg::OFS_STATUS, 32'h1);
        rd(dio_pkg::OFS_DRIVE, 32'h0);
        $display("test meter fault done");
    endtask : t_meter_fault
    task automatic t_cond_act();
        int a;
        wr(dio_pkg::OFS_CTRL, 32'h9);
        cfg(3, 32'h314);
        cfg(4, 32'h004);
        rd(dio_pkg::OFS_DRIVE, 32'h10);
        @(posedge sys_clk) begin
            clk_en <= 1'b0;
            inst.voltage_above_limit <= 1'b1;
        end
        tick(3);
        chk(32'(line_oe), 32'h10);
        @(posedge sys_clk) clk_en <= 1'b1;
        wait_sig(3, 5, 1'b1);
        @(posedge sys_clk) inst.voltage_above_limit <= 1'b0;
        tick(4);
        chk(32'(line_oe), 32'h10);
        @(posedge sys_clk) inst.sinking <= 1'b1;
        tick(4);
        chk(32'(line_oe), 32'h0);
        @(posedge sys_clk) inst.sinking <= 1'b0;
        tick(4);
        chk(32'(line_oe), 32'h0);
        for (a = 7; a <= 10; a++) begin
            cfg(5, 32'h105 | (32'(a) << 4));
            fork
                dio_partner_i.pull_low(5, 4);
                wait_sig(11 - a, 10, 1'b0);
            join
        end
        $display("test cond act done");
    endtask : t_cond_act
    task automatic t_batt();
        wr(dio_pkg::OFS_CTRL, 32'h2);
        rd(dio_pkg::OFS_CFG0 + 8'h14, 32'h0);
        cfg(3, 32'h254);
        chk(32'(line_oe), 32'h08);
        @(posedge sys_clk) inst.batt_full <= 1'b1;
        tick(4);
        chk(32'(line_oe), 32'h00);
        wr(dio_pkg::OFS_CTRL, 32'h1);
        cfg(3, 32'h134);
        @(posedge sys_clk) inst.constant_voltage <= 1'b1;
        tick(4);
        chk(32'(line_oe), 32'h08);
        cfg(4, 32'h344);
        @(posedge sys_clk) inst.end_met <= 1'b1;
        tick(4);
        chk(32'(line_oe), 32'h18);
        @(posedge sys_clk) rst_b <= 1'b0;
        tick(2);
        @(posedge sys_clk) rst_b <= 1'b1;
        tick(2);
        rd(dio_pkg::OFS_CFG0, 32'h0);
        chk(32'(line_oe), 32'h0);
        $display("test battery modes done");
    endtask : t_batt
////////////////////////////////
    initial begin
        req         = '0;
        inst        = '0;
        rst_b       = 1'b0;
        clk_en      = 1'b1;
        bad_count   = 0;
        comparisons = 0;
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        tick(1);
        t_basic();
        t_trig();
        t_meter_fault();
        t_cond_act();
        t_batt();
        give_verdict();
    end
endmodule : six_line_dio_bench
